// ### odsl_loader.sv
/*
  octal dac serial loader: takes 11-bit words from a three-wire host port
  and keeps eight 8-bit channel codes with shutdown and midscale preset.
  assumes a free-running system clock, a host serial clock on its own
  port, and chip select held high for at least four system clock periods
  between frames so the finished word is copied before it changes.
*/
`timescale 1ns/1ns

// What this block does
// - shift one bit per rising serial clock
// - serial clock ignored while chip select high
// - chip select rise loads addressed channel
// - last eleven shifted bits form the word
// - decoder enables exactly one of eight channels
// - low eight bits become channel code
// - excess leading bits are dropped
// - word is three address, eight code bits
// - shutdown opens all eight outputs
// - shutdown keeps every channel code
// - preset low loads midscale 128 everywhere
module odsl_loader
  import odsl_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CH
)
(
  input  wire logic                       i_clock,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_serial_clk,
  input  wire logic                       i_chip_select_n,
  input  wire logic                       i_serial_data_in,
  input  wire logic                       i_power_down_n,
  input  wire logic                       i_midscale_preset_n,
  output logic [CHANNELS*CODE_W-1:0]      o_channel_outputs,
  output logic [CHANNELS-1:0]             o_output_enable,
  output logic                            o_load_pulse,
  output logic [ADDR_W-1:0]               o_last_address,
  output logic [COUNT_W-1:0]              o_load_count,
  output logic                            o_frame_active
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // address field of a word, bit 10 is the msb of the address
  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [WORD_W-1:0] w
  );
    word_addr = w[ADDR_MSB:ADDR_LSB];
  endfunction : word_addr

  // code field of a word: the final eight bits shifted in
  function automatic logic [CODE_W-1:0] word_code(
    input logic [WORD_W-1:0] w
  );
    word_code = w[CODE_MSB:CODE_LSB];
  endfunction : word_code

  // one-hot channel enable; index n is output channel n
  function automatic logic [CHANNELS-1:0] addr_onehot(
    input logic [ADDR_W-1:0] a
  );
    logic [CHANNELS-1:0] hot;
    hot = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (a == ADDR_W'(i)) begin
        hot[i] = 1'b1;
      end
    end
    addr_onehot = hot;
  endfunction : addr_onehot

  // all-enabled mask for the live outputs
  function automatic logic [CHANNELS-1:0] all_on();
    all_on = '1;
  endfunction : all_on

  // ---------------------------------------------------------------------
  // link side
  // ---------------------------------------------------------------------
  odsl_link_if link_bus ();

  odsl_shifter u_shifter (
    .i_serial_clk     (i_serial_clk),
    .i_chip_select_n  (i_chip_select_n),
    .i_serial_data_in (i_serial_data_in),
    .link             (link_bus.link)
  );

  // ---------------------------------------------------------------------
  // core state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_LEN-1:0]                 cs_sync;
    logic                                cs_seen;
    logic [SYNC_LEN-1:0]                 pd_sync;
    logic [SYNC_LEN-1:0]                 pre_sync;
    logic [CHANNELS-1:0][CODE_W-1:0]     codes;
    logic [CHANNELS-1:0]                 out_en;
    logic                                load_pulse;
    logic [ADDR_W-1:0]                   last_addr;
    logic [COUNT_W-1:0]                  load_count;
    logic                                frame_active;
  } odsl_core_state_t;

  odsl_core_state_t state_q;
  odsl_core_state_t state_d;

  // ---------------------------------------------------------------------
  // derived levels
  // ---------------------------------------------------------------------
  // only the second stage of each synchroniser is looked at
  logic cs_level;
  logic pd_active;
  logic preset_active;
  logic load_edge;

  always_comb begin
    cs_level      = state_q.cs_sync[1];
    pd_active     = !state_q.pd_sync[1];
    preset_active = !state_q.pre_sync[1];
    // rising chip select seen in the system domain; the shifter has been
    // frozen since the final serial edge, so the word is stable here
    load_edge     = cs_level && !state_q.cs_seen;
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  logic [WORD_W-1:0]    word_now;
  logic [ADDR_W-1:0]    addr_now;
  logic [CODE_W-1:0]    code_now;
  logic [CHANNELS-1:0]  hit;

  always_comb begin
    word_now = link_bus.word;
    addr_now = word_addr(word_now);
    code_now = word_code(word_now);
    hit      = addr_onehot(addr_now);
  end

  always_comb begin
    state_d = state_q;

    // synchronisers: two flops on every pin that meets the system clock
    state_d.cs_sync  = {state_q.cs_sync[0], i_chip_select_n};
    state_d.pd_sync  = {state_q.pd_sync[0], i_power_down_n};
    state_d.pre_sync = {state_q.pre_sync[0], i_midscale_preset_n};
    state_d.cs_seen  = cs_level;

    state_d.frame_active = !cs_level;
    state_d.load_pulse   = 1'b0;

    if (preset_active) begin
      // preset wins over a load landing in the same cycle
      for (int i = 0; i < CHANNELS; i++) begin
        state_d.codes[i] = MIDSCALE;
      end
    end else if (load_edge) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (hit[i]) begin
          state_d.codes[i] = code_now;
        end
      end
      state_d.load_pulse = 1'b1;
      state_d.last_addr  = addr_now;
      state_d.load_count = state_q.load_count + COUNT_W'(1);
    end

    // shutdown only gates the outputs; codes are untouched
    if (pd_active) begin
      state_d.out_en = '0;
    end else begin
      state_d.out_en = all_on();
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  // the synchronisers reset to the idle level of their pins so no false
  // load edge or shutdown is seen after release
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q.cs_sync      <= SYNC_HIGH;
      state_q.cs_seen      <= 1'b1;
      state_q.pd_sync      <= SYNC_HIGH;
      state_q.pre_sync     <= SYNC_HIGH;
      for (int i = 0; i < CHANNELS; i++) begin
        state_q.codes[i]   <= CODE_RST;
      end
      state_q.out_en       <= '0;
      state_q.load_pulse   <= 1'b0;
      state_q.last_addr    <= '0;
      state_q.load_count   <= COUNT_RST;
      state_q.frame_active <= 1'b0;
    end else begin
      state_q              <= state_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      o_channel_outputs[i*CODE_W +: CODE_W] = state_q.codes[i];
    end
  end

  assign o_output_enable = state_q.out_en;
  assign o_load_pulse    = state_q.load_pulse;
  assign o_last_address  = state_q.last_addr;
  assign o_load_count    = state_q.load_count;
  assign o_frame_active  = state_q.frame_active;

endmodule : odsl_loader

// ### odsl_pkg.sv
/*
  shared constants of the octal dac serial loader: word layout, channel
  count, reset and preset codes, synchroniser depth.
  assumes nothing of its surroundings; it is compiled first.
*/
package odsl_pkg;

  // ---------------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------------
  localparam int unsigned WORD_W    = 11;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned CODE_W    = 8;
  localparam int unsigned ADDR_LSB  = 8;
  localparam int unsigned ADDR_MSB  = 10;
  localparam int unsigned CODE_LSB  = 0;
  localparam int unsigned CODE_MSB  = 7;

  // ---------------------------------------------------------------------
  // channels and values
  // ---------------------------------------------------------------------
  localparam int unsigned NUM_CH    = 8;
  localparam logic [7:0]  MIDSCALE  = 8'h80;
  localparam logic [7:0]  CODE_RST  = 8'h80;
  localparam int unsigned COUNT_W   = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ---------------------------------------------------------------------
  // crossing
  // ---------------------------------------------------------------------
  localparam int unsigned SYNC_LEN  = 2;
  localparam logic [1:0]  SYNC_HIGH = 2'h3;
  localparam logic [1:0]  SYNC_LOW  = 2'h0;

endpackage : odsl_pkg

// ### odsl_link_if.sv
/*
  carrier between the serial-clock shifter and the system-clock core.
  assumes the word only changes while chip select is low and is stable
  from the last serial clock edge of a frame until the next frame.
*/
`timescale 1ns/1ns

interface odsl_link_if;
  import odsl_pkg::*;

  logic [WORD_W-1:0] word;

  modport link (
    output word
  );

  modport core (
    input  word
  );

endinterface : odsl_link_if

// ### odsl_shifter.sv
/*
  serial input register on the host's serial clock.
  assumes chip select and serial data meet setup and hold to the rising
  serial clock edge, and that the serial clock stands still or is ignored
  while chip select is high.
*/
`timescale 1ns/1ns

module odsl_shifter
  import odsl_pkg::*;
(
  input  wire logic i_serial_clk,
  input  wire logic i_chip_select_n,
  input  wire logic i_serial_data_in,
  odsl_link_if.link link
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] shreg;
  } odsl_shift_state_t;

  odsl_shift_state_t state_q;
  odsl_shift_state_t state_d;

  // ---------------------------------------------------------------------
  // shifting
  // ---------------------------------------------------------------------
  // no reset here: the link clock may not run during system reset, and
  // the content is only used after a frame has filled it
  always_comb begin
    state_d = state_q;
    if (!i_chip_select_n) begin
      // older bits fall off the top, so only the last word stays
      state_d.shreg = {state_q.shreg[WORD_W-2:0],
                       i_serial_data_in};
    end
  end

  always_ff @(posedge i_serial_clk) begin
    state_q <= state_d;
  end

  assign link.word = state_q.shreg;

endmodule : odsl_shifter

// ### odsl_host_model.sv
/*
  host port model: drives chip select, serial clock and serial data.
  assumes the loader samples serial data on the rising serial clock.
*/
`timescale 1ns/1ns

module odsl_host_model (
  output logic o_serial_clk,
  output logic o_chip_select_n,
  output logic o_serial_data_in
);
  initial begin
    o_serial_clk     = 1'b1;
    o_chip_select_n  = 1'b1;
    o_serial_data_in = 1'b0;
  end

  // clock stands high between frames, 6 ns period inside them;
  // frame low keeps select high to show that stray clocks do nothing
  task automatic send(input logic [15:0] w, input int n, input bit frame);
    o_chip_select_n = !frame;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_clk     = 1'b0;
      o_serial_data_in = w[i];
      #3;
      o_serial_clk = 1'b1;
      #3;
    end
    // select stays low across a system clock edge, so even an empty
    // frame is seen by the loader before it ends
    #12;
    o_chip_select_n  = 1'b1;
    o_serial_data_in = !o_serial_data_in;
  endtask : send
endmodule : odsl_host_model

// ### odsl_loader_checker.sv
/*
  timing checks on the loader's ports.
  assumes load pulse 2-3 edges after select rise, sync latency 3.
*/
`timescale 1ns/1ns

module odsl_loader_checker
  import odsl_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CH
)
(
  input wire logic                  i_clock,
  input wire logic                  i_sys_rst,
  input wire logic                  i_serial_clk,
  input wire logic                  i_chip_select_n,
  input wire logic                  i_serial_data_in,
  input wire logic                  i_power_down_n,
  input wire logic                  i_midscale_preset_n,
  input wire logic [CHANNELS*8-1:0] o_channel_outputs,
  input wire logic [CHANNELS-1:0]   o_output_enable,
  input wire logic                  o_load_pulse,
  input wire logic [ADDR_W-1:0]     o_last_address,
  input wire logic [COUNT_W-1:0]    o_load_count,
  input wire logic                  o_frame_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  logic [CHANNELS*8-1:0] prev_q;
  logic [CHANNELS-1:0]   chg;
  always_ff @(posedge i_clock) prev_q <= o_channel_outputs;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      chg[i] = prev_q[i*8 +: 8] != o_channel_outputs[i*8 +: 8];
    end
  end

  a_load_follows_select: assert property (
    $rose(i_chip_select_n) && i_midscale_preset_n |-> ##[2:3] o_load_pulse)
    else $error("no load after select rise");
  a_pulse_single: assert property (o_load_pulse |=> !o_load_pulse)
    else $error("load pulse too long");
  a_count_steps: assert property (
    o_load_pulse |-> o_load_count == 16'($past(o_load_count) + 1'b1))
    else $error("count did not step");
  a_status_hold: assert property (
    !o_load_pulse |-> $stable(o_load_count) && $stable(o_last_address))
    else $error("status moved without load");
  a_one_channel: assert property (
    o_load_pulse |-> (chg & ~(CHANNELS'(1) << o_last_address)) == '0)
    else $error("load touched another channel");
  a_shutdown_open: assert property (
    !i_power_down_n [*3] |=> o_output_enable == '0)
    else $error("outputs not opened");
  a_enable_driven: assert property (
    i_power_down_n [*3] |=> o_output_enable == {CHANNELS{1'b1}})
    else $error("outputs not driven");
  a_preset_mid: assert property (
    !i_midscale_preset_n [*3] |=> o_channel_outputs == {CHANNELS{MIDSCALE}})
    else $error("preset missed midscale");
  a_codes_hold: assert property (
    i_midscale_preset_n [*5] ##0 !o_load_pulse |-> $stable(o_channel_outputs))
    else $error("codes moved without load");
  a_frame_opens: assert property (
    !i_chip_select_n [*3] |=> o_frame_active)
    else $error("frame not flagged");
  a_frame_closes: assert property (
    i_chip_select_n [*3] |=> !o_frame_active)
    else $error("frame flag stuck");
endmodule : odsl_loader_checker

bind odsl_loader odsl_loader_checker #(.CHANNELS(CHANNELS))
  i_odsl_loader_checker (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_serial_clk(i_serial_clk),
  .i_chip_select_n(i_chip_select_n), .i_serial_data_in(i_serial_data_in),
  .i_power_down_n(i_power_down_n),
  .i_midscale_preset_n(i_midscale_preset_n),
  .o_channel_outputs(o_channel_outputs), .o_output_enable(o_output_enable),
  .o_load_pulse(o_load_pulse), .o_last_address(o_last_address),
  .o_load_count(o_load_count), .o_frame_active(o_frame_active));

// ### testbench.sv
/*
  self-checking bench of the loader with a host model on the serial port.
  assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ns

module testbench;
  import odsl_pkg::*;
  logic        i_clock, i_sys_rst, sclk, cs_n, serial_data_in, pd_n, pre_n, pulse;
  logic        frame;
  logic [63:0] codes, exp_codes;
  logic [7:0]  oe;
  logic [2:0]  addr;
  logic [15:0] cnt, exp_cnt;
  int          num_errors, checks_done, cycles;

  odsl_host_model i_odsl_host_model (.o_serial_clk(sclk),
    .o_chip_select_n(cs_n), .o_serial_data_in(serial_data_in));
  odsl_loader i_odsl_loader (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_serial_clk(sclk), .i_chip_select_n(cs_n), .i_serial_data_in(serial_data_in),
    .i_power_down_n(pd_n), .i_midscale_preset_n(pre_n),
    .o_channel_outputs(codes), .o_output_enable(oe), .o_load_pulse(pulse),
    .o_last_address(addr), .o_load_count(cnt), .o_frame_active(frame));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = !i_clock;
  end

  task automatic check(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // an empty frame reloads whatever the shift register still holds
  task automatic load(input logic [15:0] w, input int n);
    int k;
    k = 0;
    i_odsl_host_model.send(w, n, 1'b1);
    while (pulse !== 1'b1 && k < 10) begin
      @(negedge i_clock);
      k++;
    end
    check(k < 10, "no load pulse");
    repeat (2) @(negedge i_clock);
    exp_codes[w[10:8]*8 +: 8] = w[7:0];
    exp_cnt++;
    check(codes === exp_codes, "channel codes wrong");
    check(addr === w[10:8] && cnt === exp_cnt, "status wrong");
    check(frame === 1'b0, "frame still active");
  endtask : load

  task automatic t_all_channels();
    for (int a = 0; a < 8; a++) begin
      load({5'h1F, 3'(a), 8'(8'h0F + a * 8'h21)}, 11);
    end
  endtask : t_all_channels

  task automatic t_long_and_stray();
    load(16'hAB5C, 16);
    i_odsl_host_model.send(16'hFFFF, 11, 1'b0);
    repeat (6) @(negedge i_clock);
    check(cnt === exp_cnt, "load with select high");
    load(16'hAB5C, 0);
  endtask : t_long_and_stray

  task automatic t_power(input logic pd, input logic pre);
    @(posedge i_clock);
    pd_n  <= pd;
    pre_n <= pre;
    repeat (5) @(negedge i_clock);
    if (!pre) exp_codes = {8{MIDSCALE}};
    check(oe === {8{pd}}, "enables wrong");
    check(codes === exp_codes, "codes lost");
  endtask : t_power

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    {num_errors, checks_done, cycles} = '0;
    {i_sys_rst, pd_n, pre_n} = 3'h7;
    exp_codes = {8{CODE_RST}};
    exp_cnt   = COUNT_RST;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (3) @(negedge i_clock);
    check(codes === exp_codes && cnt === exp_cnt, "reset values");
    check(oe === 8'hFF && addr === 3'h0 && pulse === 1'b0 &&
          frame === 1'b0, "reset status");
    t_all_channels();
    t_long_and_stray();
    t_power(1'b0, 1'b1);
    t_power(1'b1, 1'b1);
    t_power(1'b1, 1'b0);
    t_power(1'b1, 1'b1);
    load(16'h07FF, 11);
    wrap_up();
  end
endmodule : testbench
